// file: ext_mem_regs.vh
`ifndef EXT_MEM_REGS_VH
`define EXT_MEM_REGS_VH

// ----------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------
`define CLK_HZ 200000000
`define CLK_PERIOD_NS 5
`define NVM_HZ 400000
`define NVM_HALF_CYC (`CLK_HZ / (2 * `NVM_HZ))
`define ACC_FAST_NS 20
`define ACC_SLOW_NS 120
`define ACC_FAST_CYC ((`ACC_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACC_SLOW_CYC ((`ACC_SLOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Address space
// ----------------------------------------------------------------
`define ADDR_W 22
`define CODE_TOP_LSB 17
`define USB_TOP_LSB 20
`define SECT_LSB 14
`define OVL_SECTS 8'h08
`define BOOT_BYTES 22'h000008

// ----------------------------------------------------------------
// Register map (byte offsets) and fields
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_OVERLAY 8'h04
`define REG_RAMTOP 8'h08
`define REG_STATUS 8'h0C
`define CTRL_CODE_W16 0
`define CTRL_DATA_W16 1
`define CTRL_USB 2
`define CTRL_FAST 3
`define CTRL_RESET 4'h0
`define OVERLAY_RESET 8'h00
`define RAMTOP_RESET 8'h10
`define STAT_STRAP 0
`define STAT_BOOT_DONE 1
`define STAT_BUSY 2

`endif

// file: serial_nvm_reader.v
`timescale 1ns/100ps
`include "ext_mem_regs.vh"

// Streams bytes from a serial memory, MSB first, sampled on each
// rising serial clock edge while enabled.
module serial_nvm_reader (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Control and byte output
  input wire enable,
  output reg byte_valid,
  output reg [7:0] byte_data,
  // Serial pins
  input wire nvm_data_in,
  output reg nvm_clk,
  output reg nvm_select_n
);

  reg [2:0] sync_reg;
  reg bit_reg;
  reg [8:0] div_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;

  // Three-stage pin synchroniser, value taken when stages 2 and 3 agree
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_reg <= 3'h0;
      bit_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[1:0], nvm_data_in};
      if (sync_reg[1] == sync_reg[2])
        bit_reg <= sync_reg[2];
    end
  end

  // Divider makes the serial clock; a cut frame still ends low
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      div_reg <= 9'h000;
      nvm_clk <= 1'b0;
      nvm_select_n <= 1'b1;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      nvm_select_n <= ~(enable | nvm_clk);
      if (!enable && !nvm_clk) begin
        div_reg <= 9'h000;
        nvm_clk <= 1'b0;
        bit_cnt_reg <= 3'h0;
      end else if ({23'h000000, div_reg} == `NVM_HALF_CYC - 1) begin
        div_reg <= 9'h000;
        nvm_clk <= ~nvm_clk;
        if (!nvm_clk) begin
          shift_reg <= {shift_reg[6:0], bit_reg};
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7) begin
            byte_valid <= 1'b1;
            byte_data <= {shift_reg[6:0], bit_reg};
          end
        end
      end else begin
        div_reg <= div_reg + 9'h001;
      end
    end
  end

endmodule // serial_nvm_reader

// file: external_memory_controller.v
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "ext_mem_regs.vh"

// Functional notes
// - External space is at most 4 MB, cut to 1 MB when USB is the host.
// - Code and data spaces have their own selects; code reaches RAM by overlay, never the ROM region.
// - Up to 128 KB of code overlays RAM in 16 KB sections just below the top of RAM, section 0 lowest.
// - No slow-memory sensing; the clock runs slow after reset until firmware moves to RAM.
// - Code and data spaces are each 8 or 16 bits wide, in any mix.
// - Single x16 versus two x8 organisation comes from a strap sampled at reset.
// - An 8-bit space uses the shared pin as address LSB, low write strobe and read strobe.
// - A 16-bit space of two x8 parts uses the shared pin as high and the low strobe as low write enable.
// - A 16-bit x16 space uses the shared pin as upper and a separate pin as lower byte enable.
// - The shared pin's role follows the accessed space per cycle, from firmware settings.
// - After reset, boot logic copies a serial memory image into RAM at 400 kHz.
module external_memory_controller (
  // Clock and reset
  input wire clk,
  input wire reset,
  // AHB-Lite register slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Processor memory requests
  input wire req_valid,
  input wire req_code,
  input wire [21:0] req_addr,
  input wire req_write,
  input wire req_word,
  input wire [15:0] req_wdata,
  output wire req_ready,
  output reg resp_valid,
  output reg resp_err,
  output reg [15:0] resp_rdata,
  // Clock rate and boot status
  output wire instr_clk_slow,
  output wire boot_done,
  // Parallel memory pins
  output reg [21:1] mem_addr,
  output reg code_select_n,
  output reg data_select_n,
  output reg shared_byte_select_pin,
  output reg low_write_strobe_n,
  output reg lower_byte_enable_n,
  output reg memory_read_strobe_n,
  input wire [15:0] mem_data_in,
  output reg [15:0] mem_data_out,
  output reg mem_data_oe,
  // Strap and serial memory pins
  input wire config_strap_pin,
  input wire nvm_data_in,
  output wire nvm_clk,
  output wire nvm_select_n
);

  localparam S_IDLE = 3'h0;
  localparam S_SETUP = 3'h1;
  localparam S_ACC = 3'h2;
  localparam S_HOLD = 3'h3;
  localparam S_RESP = 3'h4;

  // ----------------------------------------------------------------
  // Register file over AHB-Lite
  // ----------------------------------------------------------------
  reg [3:0] ctrl_reg;
  reg [7:0] overlay_reg;
  reg [7:0] ramtop_reg;
  reg [7:0] ahb_addr_reg;
  reg ahb_wr_reg;
  reg strap_x16_reg;
  reg boot_done_reg;
  reg [2:0] state_reg;
  wire ahb_take;
  reg [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign ahb_take = hsel & htrans[1] & hready;

  // Read value prepared in the address phase, shown in the data phase
  always @* begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `REG_CTRL: rd_mux[3:0] = ctrl_reg;
      `REG_OVERLAY: rd_mux[7:0] = overlay_reg;
      `REG_RAMTOP: rd_mux[7:0] = ramtop_reg;
      `REG_STATUS: begin
        rd_mux[`STAT_STRAP] = strap_x16_reg;
        rd_mux[`STAT_BOOT_DONE] = boot_done_reg;
        rd_mux[`STAT_BUSY] = (state_reg != S_IDLE);
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Writes land in the data phase, word wide only
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      ahb_addr_reg <= 8'h00;
      ahb_wr_reg <= 1'b0;
      hrdata <= 32'h00000000;
      ctrl_reg <= `CTRL_RESET;
      overlay_reg <= `OVERLAY_RESET;
      ramtop_reg <= `RAMTOP_RESET;
    end else begin
      ahb_wr_reg <= ahb_take & hwrite;
      if (ahb_take) begin
        ahb_addr_reg <= haddr[7:0];
        hrdata <= rd_mux;
      end
      if (ahb_wr_reg) begin
        case (ahb_addr_reg)
          `REG_CTRL: ctrl_reg <= hwdata[3:0];
          `REG_OVERLAY: overlay_reg <= hwdata[7:0];
          `REG_RAMTOP: ramtop_reg <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // Slow until firmware declares it runs from RAM
  assign instr_clk_slow = ~ctrl_reg[`CTRL_FAST];

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  reg [2:0] strap_sync_reg, strap_age_reg;
  reg strap_done_reg;

  // The strap is only trusted once two late stages agree
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_sync_reg <= 3'h0;
      strap_age_reg <= 3'h0;
      strap_done_reg <= 1'b0;
      strap_x16_reg <= 1'b0;
    end else begin
      strap_sync_reg <= {strap_sync_reg[1:0], config_strap_pin};
      strap_age_reg <= {strap_age_reg[1:0], 1'b1};
      if (!strap_done_reg && strap_age_reg[2] &&
          strap_sync_reg[1] == strap_sync_reg[2]) begin
        strap_x16_reg <= strap_sync_reg[2];
        strap_done_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Boot copy from the serial memory
  // ----------------------------------------------------------------
  wire nvm_byte_valid;
  wire [7:0] nvm_byte;
  reg boot_pend_reg;
  reg [7:0] boot_byte_reg;
  reg [21:0] boot_addr_reg;
  wire boot_take;
  wire boot_run;

  assign boot_run = strap_done_reg & ~boot_done_reg;
  assign boot_done = boot_done_reg;

  serial_nvm_reader u_reader (
    .clk(clk),
    .reset(reset),
    .enable(boot_run),
    .byte_valid(nvm_byte_valid),
    .byte_data(nvm_byte),
    .nvm_data_in(nvm_data_in),
    .nvm_clk(nvm_clk),
    .nvm_select_n(nvm_select_n)
  );

  // A fresh byte beats the clear of the pending flag
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      boot_pend_reg <= 1'b0;
      boot_byte_reg <= 8'h00;
      boot_addr_reg <= 22'h000000;
      boot_done_reg <= 1'b0;
    end else begin
      if (nvm_byte_valid) begin
        boot_pend_reg <= 1'b1;
        boot_byte_reg <= nvm_byte;
      end else if (boot_take) begin
        boot_pend_reg <= 1'b0;
      end
      if (boot_take)
        boot_addr_reg <= boot_addr_reg + 22'h000001;
      if (boot_run && !boot_pend_reg && boot_addr_reg == `BOOT_BYTES)
        boot_done_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Request decode: limits, ROM region and overlay
  // ----------------------------------------------------------------
  wire [2:0] sect;
  wire ovl_hit;
  wire rom_hit;
  wire lim_err;
  wire [7:0] ram_sect;
  wire proc_take;

  assign sect = req_addr[`SECT_LSB+2:`SECT_LSB];
  assign rom_hit = req_code & (|req_addr[21:`CODE_TOP_LSB]);
  assign ovl_hit = req_code & ~rom_hit & overlay_reg[sect];
  // Overlay sections count up to the top of physical RAM, section 0 lowest
  assign ram_sect = ramtop_reg - `OVL_SECTS + {5'h00, sect};
  assign lim_err = ctrl_reg[`CTRL_USB] &
                   (|req_addr[21:`USB_TOP_LSB]);

  // Boot owns the memory until its copy ends
  assign boot_take = (state_reg == S_IDLE) & boot_pend_reg;
  assign req_ready = (state_reg == S_IDLE) & boot_done_reg;
  assign proc_take = req_ready & req_valid;

  // ----------------------------------------------------------------
  // Memory cycle sequencer
  // ----------------------------------------------------------------
  reg cur_code_reg;
  reg [21:0] cur_addr_reg;
  reg cur_write_reg;
  reg cur_word_reg;
  reg [15:0] cur_wdata_reg;
  reg cur_proc_reg;
  reg cur_err_reg;
  reg phase_reg;
  reg [4:0] acc_cnt_reg;
  reg [15:0] rdata_reg;
  wire cur_w16;
  wire two_phase;
  wire [31:0] acc_len;

  // Width of whichever space this cycle targets
  assign cur_w16 = cur_code_reg ? ctrl_reg[`CTRL_CODE_W16]
                                : ctrl_reg[`CTRL_DATA_W16];
  assign two_phase = cur_word_reg & ~cur_w16;
  assign acc_len = ctrl_reg[`CTRL_FAST] ? `ACC_FAST_CYC - 1
                                        : `ACC_SLOW_CYC - 1;

  // Byte lanes wanted in a 16-bit cycle
  function [1:0] lanes;
    input word;
    input a0;
    begin
      lanes = word ? 2'h3 : (a0 ? 2'h2 : 2'h1);
    end
  endfunction

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= S_IDLE;
      cur_code_reg <= 1'b0;
      cur_addr_reg <= 22'h000000;
      cur_write_reg <= 1'b0;
      cur_word_reg <= 1'b0;
      cur_wdata_reg <= 16'h0000;
      cur_proc_reg <= 1'b0;
      cur_err_reg <= 1'b0;
      phase_reg <= 1'b0;
      acc_cnt_reg <= 5'h00;
      rdata_reg <= 16'h0000;
      resp_valid <= 1'b0;
      resp_err <= 1'b0;
      resp_rdata <= 16'h0000;
    end else begin
      resp_valid <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          phase_reg <= 1'b0;
          if (boot_take) begin
            cur_code_reg <= 1'b0;
            cur_addr_reg <= boot_addr_reg;
            cur_write_reg <= 1'b1;
            cur_word_reg <= 1'b0;
            cur_wdata_reg <= {boot_byte_reg, boot_byte_reg};
            cur_proc_reg <= 1'b0;
            cur_err_reg <= 1'b0;
            state_reg <= S_SETUP;
          end else if (proc_take) begin
            cur_code_reg <= req_code & ~ovl_hit;
            cur_addr_reg <= ovl_hit ? {ram_sect, req_addr[13:0]} : req_addr;
            cur_write_reg <= req_write;
            cur_word_reg <= req_word;
            cur_wdata_reg <= req_wdata;
            cur_proc_reg <= 1'b1;
            cur_err_reg <= rom_hit | lim_err;
            // Refused accesses never assert a memory select, strobe or data drive
            state_reg <= (rom_hit | lim_err) ? S_RESP : S_SETUP;
          end
        end
        S_SETUP: begin
          acc_cnt_reg <= acc_len[4:0];
          state_reg <= S_ACC;
        end
        S_ACC: begin
          if (acc_cnt_reg == 5'h00)
            state_reg <= S_HOLD;
          else
            acc_cnt_reg <= acc_cnt_reg - 5'h01;
        end
        S_HOLD: begin
          // Pins still show the strobes of the last access cycle here
          if (!cur_write_reg) begin
            if (cur_w16)
              rdata_reg <= cur_word_reg ? mem_data_in :
                           {8'h00, cur_addr_reg[0] ? mem_data_in[15:8]
                                                   : mem_data_in[7:0]};
            else if (phase_reg)
              rdata_reg[15:8] <= mem_data_in[7:0];
            else
              rdata_reg <= {8'h00, mem_data_in[7:0]};
          end
          if (two_phase && !phase_reg) begin
            phase_reg <= 1'b1;
            state_reg <= S_SETUP;
          end else begin
            state_reg <= S_RESP;
          end
        end
        S_RESP: begin
          resp_valid <= cur_proc_reg;
          resp_err <= cur_err_reg;
          resp_rdata <= cur_err_reg ? 16'h0000 : rdata_reg;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive, one cycle behind the sequencer state
  // ----------------------------------------------------------------
  wire on_cycle;
  wire strobe;
  wire a0;
  wire [1:0] ln;
  wire [7:0] wr_byte;

  assign on_cycle = (state_reg == S_SETUP) | (state_reg == S_ACC) |
                    (state_reg == S_HOLD);
  assign strobe = (state_reg == S_ACC);
  assign a0 = cur_word_reg ? phase_reg : cur_addr_reg[0];
  assign ln = lanes(cur_word_reg, cur_addr_reg[0]);
  assign wr_byte = (two_phase && phase_reg) ? cur_wdata_reg[15:8]
                                            : cur_wdata_reg[7:0];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_addr <= 21'h000000;
      code_select_n <= 1'b1;
      data_select_n <= 1'b1;
      shared_byte_select_pin <= 1'b1;
      low_write_strobe_n <= 1'b1;
      lower_byte_enable_n <= 1'b1;
      memory_read_strobe_n <= 1'b1;
      mem_data_out <= 16'h0000;
      mem_data_oe <= 1'b0;
    end else begin
      mem_addr <= cur_addr_reg[21:1];
      code_select_n <= ~(on_cycle & cur_code_reg);
      data_select_n <= ~(on_cycle & ~cur_code_reg);
      memory_read_strobe_n <= ~(strobe & ~cur_write_reg);
      mem_data_oe <= on_cycle & cur_write_reg;
      mem_data_out <= cur_word_reg ? cur_wdata_reg : {wr_byte, wr_byte};
      if (!cur_w16) begin
        shared_byte_select_pin <= a0;
        low_write_strobe_n <= ~(strobe & cur_write_reg);
        lower_byte_enable_n <= 1'b1;
        mem_data_out <= {8'h00, wr_byte};
      end else if (strap_x16_reg) begin
        shared_byte_select_pin <= ~(on_cycle & ln[1]);
        lower_byte_enable_n <= ~(on_cycle & ln[0]);
        low_write_strobe_n <= ~(strobe & cur_write_reg);
      end else begin
        shared_byte_select_pin <= ~(strobe & cur_write_reg & ln[1]);
        low_write_strobe_n <= ~(strobe & cur_write_reg & ln[0]);
        lower_byte_enable_n <= 1'b1;
      end
    end
  end

endmodule // external_memory_controller

// file: ext_mem_checker_asserts.sv
`timescale 1ns/100ps
`include "ext_mem_regs.vh"
// ----------------------------------------
// Pin and status checks
// ----------------------------------------
module ext_mem_checker (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  // Requests and status
  input wire req_ready,
  input wire resp_valid,
  input wire resp_err,
  input wire instr_clk_slow,
  input wire boot_done,
  // Memory and serial pins
  input wire code_select_n,
  input wire data_select_n,
  input wire shared_byte_select_pin,
  input wire low_write_strobe_n,
  input wire lower_byte_enable_n,
  input wire memory_read_strobe_n,
  input wire mem_data_oe,
  input wire config_strap_pin,
  input wire nvm_clk,
  input wire nvm_select_n
);
  logic wr_p;
  logic [7:0] wa_p;
  logic [3:0] ctrl_q;
  logic [9:0] hi_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow of the control word, so pin checks know each space width
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_p <= 1'b0;
      wa_p <= 8'h00;
      ctrl_q <= 4'h0;
    end else begin
      wr_p <= hsel && htrans[1] && hready && hwrite;
      wa_p <= haddr[7:0];
      if (wr_p && wa_p == `REG_CTRL)
        ctrl_q <= hwdata[3:0];
    end
  end
  // Cycles the serial clock has stood high
  always @(posedge clk or posedge reset) begin
    if (reset)
      hi_cnt <= 10'h000;
    else
      hi_cnt <= nvm_clk ? hi_cnt + 10'h001 : 10'h000;
  end
  sel_excl_a:
    assert property (!(!code_select_n && !data_select_n))
    else $error("code and data selects low together");
  err_quiet_a:
    assert property (resp_valid && resp_err |-> code_select_n &&
      data_select_n && $past(code_select_n) && $past(data_select_n))
    else $error("refused request touched the memory pins");
  clk_rate_a:
    assert property (instr_clk_slow == !ctrl_q[3])
    else $error("instruction clock rate does not follow control");
  boot_gate_a:
    assert property (!boot_done |-> !req_ready)
    else $error("requests accepted before boot copy ended");
  nvm_still_a:
    assert property (nvm_select_n && $past(nvm_select_n) |->
      $stable(nvm_clk))
    else $error("serial clock moved while deselected");
  nvm_half_a:
    assert property ($fell(nvm_clk) |-> hi_cnt == `NVM_HALF_CYC)
    else $error("serial clock high phase has wrong length");
  x8_strobe_a:
    assert property (!data_select_n && !ctrl_q[1] |-> lower_byte_enable_n)
    else $error("byte enable used in an 8-bit space");
  pair_read_a:
    assert property (!config_strap_pin && ctrl_q[1] && !data_select_n &&
      !memory_read_strobe_n |-> shared_byte_select_pin)
    else $error("high write enable low during a read");
  strobe_excl_a:
    assert property (!(!memory_read_strobe_n && !low_write_strobe_n))
    else $error("read and write strobes low together");
  write_drive_a:
    assert property (!low_write_strobe_n |-> mem_data_oe)
    else $error("write strobe without driven data");
  strobe_sel_a:
    assert property (!memory_read_strobe_n |->
      !(code_select_n && data_select_n))
    else $error("read strobe with no space selected");
  // Main scenarios
  refused_c: cover property (resp_valid && resp_err);
  served_c: cover property (resp_valid && !resp_err);
  boot_c: cover property ($rose(boot_done));
  serial_c: cover property ($fell(nvm_clk));
endmodule // ext_mem_checker

bind external_memory_controller ext_mem_checker u_ext_mem_checker (
  .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .req_ready, .resp_valid, .resp_err, .instr_clk_slow, .boot_done,
  .code_select_n, .data_select_n, .shared_byte_select_pin,
  .low_write_strobe_n, .lower_byte_enable_n, .memory_read_strobe_n,
  .mem_data_oe, .config_strap_pin, .nvm_clk, .nvm_select_n);

// file: parallel_mem_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Board memories and serial boot part
// ----------------------------------------
module parallel_mem_model (
  // Clock and board setup
  input wire clk,
  input wire code_w16,
  input wire data_w16,
  input wire x16_org,
  // Parallel memory pins
  input wire code_select_n,
  input wire data_select_n,
  input wire shared_byte_select_pin,
  input wire low_write_strobe_n,
  input wire lower_byte_enable_n,
  input wire memory_read_strobe_n,
  input wire [21:1] mem_addr,
  input wire [15:0] mem_data_out,
  output logic [15:0] mem_data_in,
  // Serial memory pins
  input wire nvm_clk,
  input wire nvm_select_n,
  output logic nvm_data_in
);
  logic [7:0] mem_m [int];
  logic sel_any, w16, hi_n, lo_n, clk_q = 1'b0;
  int wa, nb, nxt;
  // Code bytes sit above the data range so the spaces never alias
  assign sel_any = !code_select_n || !data_select_n;
  assign w16 = code_select_n ? data_w16 : code_w16;
  assign wa = (code_select_n ? 0 : 32'h400000) + {mem_addr, 1'b0};
  // One organisation for the whole board, chosen by the strap
  assign hi_n = x16_org ? low_write_strobe_n | shared_byte_select_pin
    : shared_byte_select_pin;
  assign lo_n = x16_org ? low_write_strobe_n | lower_byte_enable_n
    : low_write_strobe_n;
  function automatic logic [7:0] rd_b(input int k);
    return mem_m.exists(k) ? mem_m[k] : ~k[7:0];
  endfunction
  function automatic logic pat(input int n);
    logic [7:0] b = 8'hA5 ^ n[10:3];
    return b[7 - n % 8];
  endfunction
  initial begin
    mem_data_in = 16'h5A5A;
    nvm_data_in = 1'b0;
  end
  // Reads answer a cycle after the strobe; idle lanes keep toggling
  always @(posedge clk) begin
    if (sel_any && !memory_read_strobe_n && w16)
      mem_data_in <= {rd_b(wa + 1), rd_b(wa)};
    else if (sel_any && !memory_read_strobe_n)
      mem_data_in <= {~mem_data_in[15:8],
        rd_b(wa + shared_byte_select_pin)};
    else
      mem_data_in <= ~mem_data_in;
    if (sel_any && !w16 && !low_write_strobe_n)
      mem_m[wa + shared_byte_select_pin] = mem_data_out[7:0];
    if (sel_any && w16 && !hi_n)
      mem_m[wa + 1] = mem_data_out[15:8];
    if (sel_any && w16 && !lo_n)
      mem_m[wa] = mem_data_out[7:0];
  end
  // Restarts at byte 0 on deselect; next bit after each falling clock
  always @(posedge clk) begin
    nxt = nvm_select_n ? 0 : nb + int'(clk_q && !nvm_clk);
    nb <= nxt;
    clk_q <= nvm_clk;
    nvm_data_in <= nvm_select_n ? ~nvm_data_in : pat(nxt);
  end
endmodule // parallel_mem_model

// file: external_memory_controller_tb.sv
`timescale 1ns/100ps
module external_memory_controller_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk, reset, hsel, hwrite, req_valid, req_code, req_write, req_word;
  logic rq_err;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [21:0] req_addr;
  logic [15:0] req_wdata, rq_data;
  logic [3:0] ctrl_sh;
  logic config_strap_pin = 1'b1;
  logic [31:0] ra [4] = '{32'h0, 32'h4, 32'h8, 32'h10};
  logic [31:0] re [4] = '{32'h0, 32'h0, 32'h10, 32'h0};
  int miscompares, n_tests, i;
  wire hready, hreadyout, hresp, req_ready, resp_valid, resp_err;
  wire instr_clk_slow, boot_done, code_select_n, data_select_n;
  wire shared_byte_select_pin, low_write_strobe_n, lower_byte_enable_n;
  wire memory_read_strobe_n, mem_data_oe, nvm_data_in, nvm_clk, nvm_select_n;
  wire [31:0] hrdata;
  wire [15:0] resp_rdata, mem_data_in, mem_data_out;
  wire [21:1] mem_addr;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  external_memory_controller u_external_memory_controller (
    .clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .req_valid, .req_code,
    .req_addr, .req_write, .req_word, .req_wdata, .req_ready,
    .resp_valid, .resp_err, .resp_rdata, .instr_clk_slow, .boot_done,
    .mem_addr, .code_select_n, .data_select_n, .shared_byte_select_pin,
    .low_write_strobe_n, .lower_byte_enable_n, .memory_read_strobe_n,
    .mem_data_in, .mem_data_out, .mem_data_oe, .config_strap_pin,
    .nvm_data_in, .nvm_clk, .nvm_select_n);
  parallel_mem_model u_parallel_mem_model (
    .clk, .code_w16(ctrl_sh[0]), .data_w16(ctrl_sh[1]),
    .x16_org(config_strap_pin), .code_select_n, .data_select_n,
    .shared_byte_select_pin, .low_write_strobe_n, .lower_byte_enable_n,
    .memory_read_strobe_n, .mem_addr, .mem_data_out, .mem_data_in,
    .nvm_clk, .nvm_select_n, .nvm_data_in);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Single word transfer: address phase, then data phase
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    if (w && a == 32'h0) ctrl_sh <= d[3:0];
  endtask
  // Kind bits are code, write, word
  task mreq(input logic [2:0] k, input logic [21:0] a, input logic [15:0] d);
    @(posedge clk);
    req_valid <= 1'b1;
    {req_code, req_write, req_word} <= k;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    do @(negedge clk); while (resp_valid !== 1'b1);
    rq_data = resp_rdata;
    rq_err = resp_err;
  endtask
  task print_verdict;
    $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Two boot copies take about 65k cycles
  initial begin
    #450000;
    miscompares++;
    print_verdict;
  end
  initial begin
    {reset, hsel, hwrite, req_valid, req_code, req_write, req_word} = 7'h40;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    {req_addr, req_wdata, ctrl_sh} = 42'h0;
    repeat (16) @(posedge clk);
    chk("rst_pins", 32'hF, {code_select_n, data_select_n, instr_clk_slow,
      hreadyout});
    chk("rst_boot", 32'h0, {boot_done, req_ready, hresp, mem_data_oe,
      resp_valid});
    reset <= 1'b0;
    for (i = 0; i < 4; i++) begin
      ahb(1'b0, ra[i], 32'h0);
      chk("reg_reset", re[i], rd);
    end
    ahb(1'b1, 32'h10, 32'hFFFFFFFF);
    ahb(1'b0, 32'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (i = 0; i < 40000 && boot_done !== 1'b1; i++) @(posedge clk);
    chk("boot_done", 32'h1, boot_done);
    for (i = 0; i < 8; i += 2) begin
      mreq(3'h0, i[21:0], 16'h0);
      chk("boot_byte", 8'hA5 ^ i[7:0], rq_data[7:0]);
    end
    ahb(1'b1, 32'h0, 32'h2);
    mreq(3'h1, 22'h0, 16'h0);
    chk("x16_word", 32'hA4A5, rq_data);
    mreq(3'h5, 22'h10, 16'h0);
    chk("code_pair", 32'hEEEF, rq_data);
    mreq(3'h3, 22'h20010, 16'hBEEF);
    mreq(3'h2, 22'h20011, 16'h0077);
    mreq(3'h1, 22'h20010, 16'h0);
    chk("byte_lane", 32'h77EF, rq_data);
    ahb(1'b1, 32'h4, 32'h1);
    mreq(3'h5, 22'h10, 16'h0);
    chk("overlay_hit", 32'h77EF, rq_data);
    mreq(3'h5, 22'h4010, 16'h0);
    chk("overlay_miss", 32'hEEEF, rq_data);
    mreq(3'h5, 22'h20000, 16'h0);
    chk("rom_refused", 32'h1, rq_err);
    ahb(1'b1, 32'h0, 32'h6);
    mreq(3'h1, 22'h100000, 16'h0);
    chk("usb_limit", 32'h1, rq_err);
    mreq(3'h1, 22'h0FFFFE, 16'h0);
    chk("usb_inside", 32'h0, rq_err);
    ahb(1'b1, 32'h0, 32'hA);
    mreq(3'h1, 22'h3FFFFE, 16'h0);
    chk("full_space", 32'h0, rq_err);
    chk("fast_clk", 32'h0, instr_clk_slow);
    ahb(1'b0, 32'hC, 32'h0);
    chk("status", 32'h3, rd & 32'h3);
    {reset, config_strap_pin, ctrl_sh} <= 6'h20;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 40000 && boot_done !== 1'b1; i++) @(posedge clk);
    mreq(3'h0, 22'h5, 16'h0);
    chk("reboot_byte", 32'hA0, rq_data);
    ahb(1'b1, 32'h0, 32'h2);
    mreq(3'h3, 22'h20, 16'h1234);
    mreq(3'h1, 22'h20, 16'h0);
    chk("pair_word", 32'h1234, rq_data);
    ahb(1'b0, 32'hC, 32'h0);
    chk("strap_x8", 32'h2, rd & 32'h3);
    print_verdict;
  end
endmodule // external_memory_controller_tb
